// ### core/system_stack_address_mapper.sv
// system stack pointer, limit checks, virtual-to-physical mapping and apb registers
// How it works
// [R1] map every even F000h..FFFEh pointer
// [R2] limit pointers take same 4 KB range
// [R3] size code picks region, ends FBFEh
// [R4] software never writes codes 101b/110b
// [R5] no 512 words on 1 KB RAM
// [R6] keep significant bits, fill from FBFEh
// [R7] reset FA00h, FC00h, FC00h, size 000b
// [R8] push decrements by two, writes mapped
// [R9] below region bottom wraps to top
// [R10] code 111b disables transformation, linear
// [R11] linear stack kept F600h..FDFEh by software
// [R12] software avoids SFR and below-RAM stacks
// [R13] reaching a limit enters matching trap
// [R14] software sets overflow six words above
// [R15] no overflow detection for user stacks
// [R16] pre-decrement push only on moves
// [R17] alu post-increment pops use R0-R3 only
// [R18] decrement compares overflow, traps if below
// [R19] increment compares underflow, traps if above
// [R20] direct move loads without limit check
// [R21] pointer even, lsb forced zero
// [R22] pop reads mapped address, then adds two
module system_stack_address_mapper
    import stack_map_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [stack_map_pkg::APB_W-1:0] i_pwdata,
    output logic [stack_map_pkg::APB_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // stack operation from the core
    input wire logic i_op_valid,
    input wire stack_map_pkg::stack_op_t i_op_kind,
    input wire logic [stack_map_pkg::ADDR_W-1:0] i_op_value,
    input wire logic [stack_map_pkg::DATA_W-1:0] i_push_data,
    // internal ram access
    output logic o_ram_wr,
    output logic o_ram_rd,
    output logic [stack_map_pkg::ADDR_W-1:0] o_ram_addr,
    output logic [stack_map_pkg::DATA_W-1:0] o_ram_wdata,
    // trap requests
    output logic o_overflow_trap,
    output logic o_underflow_trap,
    // user stack addressing mode check
    input wire logic i_ustk_predec,
    input wire logic i_ustk_is_move,
    input wire logic [3:0] i_ustk_reg,
    output logic o_ustk_mode_ok,
    // current pointer for the core
    output logic [stack_map_pkg::ADDR_W-1:0] o_system_stack_pointer
);
    import stack_map_pkg::*;

    // pointer and configuration registers
    logic [15:0] system_stack_pointer_ff;
    logic [15:0] overflow_limit_pointer_ff;
    logic [15:0] underflow_limit_pointer_ff;
    logic [2:0] stack_size_select_ff;
    // sticky trap status for software
    logic ovf_seen_ff;
    logic unf_seen_ff;
    // next values
    logic [15:0] nxt_sp;
    logic nxt_ovf;
    logic nxt_unf;
    // apb decode
    logic apb_setup;
    logic apb_wr;
    logic addr_hit;
    logic stat_clr;

    // wrap any value into the virtual window, lsb dropped
    function automatic logic [15:0] to_virt(input logic [15:0] v);
        to_virt = VIRT_BASE | (v & VIRT_MOD); // [R1] [R2] [R21]
    endfunction

    // significant bit mask for a size code
    function automatic logic [15:0] size_mask(input logic [2:0] code);
        case (code)
            SZ_256: size_mask = MASK_256;
            SZ_128: size_mask = MASK_128;
            SZ_64: size_mask = MASK_64;
            SZ_32: size_mask = MASK_32;
            SZ_512: size_mask = MASK_512;
            // reserved codes behave linearly; software must not use them
            default: size_mask = MASK_LIN; // [R4] [R10]
        endcase
    endfunction

    // virtual to physical transformation
    function automatic logic [15:0] to_phys(input logic [15:0] sp, input logic [2:0] code);
        logic [15:0] m;
        m = size_mask(code);
        // upper bits come from the region top, which wraps the region
        to_phys = (sp & m) | (PHYS_TOP & ~m); // [R3] [R6] [R9] [R10]
    endfunction

    // apb strobes: zero wait, answer in the access phase
    assign apb_setup = i_psel && !i_penable;
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    always_comb begin
        // unmapped offsets answer with an error
        unique case (i_paddr)
            OFS_SP, OFS_OVF, OFS_UNF, OFS_CFG, OFS_STAT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign o_pslverr = i_psel && i_penable && !addr_hit;
    assign stat_clr = apb_wr && (i_paddr == OFS_STAT);

    // next stack pointer and limit compares
    always_comb begin
        nxt_sp = system_stack_pointer_ff;
        nxt_ovf = 1'b0;
        nxt_unf = 1'b0;
        if (i_op_valid) begin
            unique case (i_op_kind)
                OP_PUSH: begin
                    nxt_sp = to_virt(system_stack_pointer_ff - WORD_STEP); // [R8]
                    nxt_ovf = nxt_sp < overflow_limit_pointer_ff; // [R13] [R18]
                end
                OP_SUB: begin
                    nxt_sp = to_virt(system_stack_pointer_ff - i_op_value);
                    nxt_ovf = nxt_sp < overflow_limit_pointer_ff; // [R18]
                end
                OP_POP: begin
                    nxt_sp = to_virt(system_stack_pointer_ff + WORD_STEP); // [R22]
                    nxt_unf = nxt_sp > underflow_limit_pointer_ff; // [R13] [R19]
                end
                OP_ADD: begin
                    nxt_sp = to_virt(system_stack_pointer_ff + i_op_value);
                    nxt_unf = nxt_sp > underflow_limit_pointer_ff; // [R19]
                end
                OP_MOVE: begin
                    // loaded value is never compared with the limits
                    nxt_sp = to_virt(i_op_value); // [R20]
                end
                default: begin
                    nxt_sp = system_stack_pointer_ff;
                end
            endcase
        end else if (apb_wr && i_paddr == OFS_SP) begin
            // a bus write is a direct move: no check
            nxt_sp = to_virt(i_pwdata[15:0]); // [R20] [R21]
        end
    end

    // stack pointer register; the core wins over a bus write
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            system_stack_pointer_ff <= RST_SP; // [R7]
        end else begin
            system_stack_pointer_ff <= nxt_sp;
        end
    end

    // limit pointers and size select, written by software
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            overflow_limit_pointer_ff <= RST_OVF; // [R7]
            underflow_limit_pointer_ff <= RST_UNF;
            stack_size_select_ff <= RST_SIZE;
        end else if (apb_wr) begin
            if (i_paddr == OFS_OVF) begin
                overflow_limit_pointer_ff <= to_virt(i_pwdata[15:0]); // [R2]
            end
            if (i_paddr == OFS_UNF) begin
                underflow_limit_pointer_ff <= to_virt(i_pwdata[15:0]); // [R2]
            end
            if (i_paddr == OFS_CFG) begin
                stack_size_select_ff <= i_pwdata[CFG_SIZE_LSB +: 3]; // [R3]
            end
        end
    end

    // ram access strobes and address
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_ram_wr <= 1'b0;
            o_ram_rd <= 1'b0;
            o_ram_addr <= to_phys(RST_SP, RST_SIZE);
            o_ram_wdata <= '0;
        end else begin
            o_ram_wr <= i_op_valid && i_op_kind == OP_PUSH;
            o_ram_rd <= i_op_valid && i_op_kind == OP_POP;
            if (i_op_valid && i_op_kind == OP_PUSH) begin
                // push writes at the decremented, mapped pointer
                o_ram_addr <= to_phys(nxt_sp, stack_size_select_ff); // [R8] [R9]
                o_ram_wdata <= i_push_data;
            end else if (i_op_valid && i_op_kind == OP_POP) begin
                // pop reads at the current pointer before the step
                o_ram_addr <= to_phys(system_stack_pointer_ff, stack_size_select_ff); // [R22]
            end
        end
    end

    // trap pulses to the core
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_overflow_trap <= 1'b0;
            o_underflow_trap <= 1'b0;
        end else begin
            o_overflow_trap <= nxt_ovf; // [R13]
            o_underflow_trap <= nxt_unf; // [R13]
        end
    end

    // sticky trap flags; a new trap wins over a clear
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ovf_seen_ff <= 1'b0;
            unf_seen_ff <= 1'b0;
        end else begin
            ovf_seen_ff <= nxt_ovf || (ovf_seen_ff && !(stat_clr && i_pwdata[STAT_OVF_BIT]));
            unf_seen_ff <= nxt_unf || (unf_seen_ff && !(stat_clr && i_pwdata[STAT_UNF_BIT]));
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_prdata <= '0;
        end else if (apb_setup) begin
            o_prdata <= '0;
            unique case (i_paddr)
                OFS_SP: o_prdata[15:0] <= system_stack_pointer_ff;
                OFS_OVF: o_prdata[15:0] <= overflow_limit_pointer_ff;
                OFS_UNF: o_prdata[15:0] <= underflow_limit_pointer_ff;
                OFS_CFG: o_prdata[CFG_SIZE_LSB +: 3] <= stack_size_select_ff;
                OFS_STAT: begin
                    o_prdata[STAT_OVF_BIT] <= ovf_seen_ff;
                    o_prdata[STAT_UNF_BIT] <= unf_seen_ff;
                end
                default: o_prdata <= '0;
            endcase
        end
    end

    // user stack modes: no limit hardware exists for them at all
    always_comb begin
        if (i_ustk_predec) begin
            o_ustk_mode_ok = i_ustk_is_move; // [R15] [R16]
        end else begin
            // post-increment pops: moves any reg, alu only the first four
            o_ustk_mode_ok = i_ustk_is_move || (i_ustk_reg <= ALU_PTR_LAST); // [R17]
        end
    end

    assign o_system_stack_pointer = system_stack_pointer_ff;

    // ---------------- assertions ----------------
    // a push request from the core
    sequence s_push_req;
        i_op_valid && i_op_kind == OP_PUSH;
    endsequence

    // a pop request from the core
    sequence s_pop_req;
        i_op_valid && i_op_kind == OP_POP;
    endsequence

    a_sp_even_lsb: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R21]
        system_stack_pointer_ff[0] == 1'b0)
        else $error("stack pointer is odd");

    a_sp_window: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R1]
        system_stack_pointer_ff[15:12] == VIRT_BASE[15:12])
        else $error("stack pointer left the virtual window");

    a_reset_values: assert property (@(posedge i_ref_clk) // [R7]
        $past(i_sys_rst) |-> system_stack_pointer_ff == RST_SP
            && overflow_limit_pointer_ff == RST_OVF && stack_size_select_ff == RST_SIZE)
        else $error("wrong values after reset");

    a_push_step: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R8]
        s_push_req |=> system_stack_pointer_ff == to_virt($past(system_stack_pointer_ff) - WORD_STEP)
            && o_ram_wr)
        else $error("push did not step the pointer down by two");

    a_pop_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R22]
        s_pop_req |=> o_ram_rd
            && o_ram_addr == to_phys($past(system_stack_pointer_ff), $past(stack_size_select_ff)))
        else $error("pop did not read the current mapped address");

    a_wrap_256: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R9]
        s_push_req and (system_stack_pointer_ff == 16'hf800 && stack_size_select_ff == SZ_256)
            |=> o_ram_addr == 16'hfbfe)
        else $error("circular wrap failed");

    a_linear_direct: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R10]
        s_push_req and (stack_size_select_ff == SZ_LIN)
            |=> o_ram_addr == system_stack_pointer_ff)
        else $error("linear mode transformed the address");

    a_ovf_trap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R18]
        s_push_req and (to_virt(system_stack_pointer_ff - WORD_STEP) < overflow_limit_pointer_ff)
            |=> o_overflow_trap && ovf_seen_ff)
        else $error("overflow trap missing");

    a_unf_trap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R19]
        s_pop_req and (to_virt(system_stack_pointer_ff + WORD_STEP) > underflow_limit_pointer_ff)
            |=> o_underflow_trap)
        else $error("underflow trap missing");

    a_move_no_check: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R20]
        i_op_valid && i_op_kind == OP_MOVE |=> !o_overflow_trap && !o_underflow_trap)
        else $error("move raised a trap");

    a_alu_pointer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R17]
        !i_ustk_predec && !i_ustk_is_move && i_ustk_reg > ALU_PTR_LAST |-> !o_ustk_mode_ok)
        else $error("alu pop accepted a high register");
endmodule

// ### core/stack_map_pkg.sv
// constants and types shared by the system stack address mapper
package stack_map_pkg;
    // address and data widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int APB_W = 32;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_SP = 8'h00;
    localparam logic [7:0] OFS_OVF = 8'h04;
    localparam logic [7:0] OFS_UNF = 8'h08;
    localparam logic [7:0] OFS_CFG = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // reset values
    localparam logic [15:0] RST_SP = 16'hfc00;
    localparam logic [15:0] RST_OVF = 16'hfa00;
    localparam logic [15:0] RST_UNF = 16'hfc00;
    localparam logic [2:0] RST_SIZE = 3'h0;
    // virtual window: top nibble fixed, lsb always zero
    localparam logic [15:0] VIRT_BASE = 16'hf000;
    localparam logic [15:0] VIRT_MOD = 16'h0ffe;
    // upper limit of every circular physical region
    localparam logic [15:0] PHYS_TOP = 16'hfbfe;
    // stack word step in bytes
    localparam logic [15:0] WORD_STEP = 16'h0002;
    // significant stack pointer bits per size code
    localparam logic [15:0] MASK_256 = 16'h01ff;
    localparam logic [15:0] MASK_128 = 16'h00ff;
    localparam logic [15:0] MASK_64 = 16'h007f;
    localparam logic [15:0] MASK_32 = 16'h003f;
    localparam logic [15:0] MASK_512 = 16'h03ff;
    localparam logic [15:0] MASK_LIN = 16'hffff;
    // field positions
    localparam int CFG_SIZE_LSB = 0;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_UNF_BIT = 1;
    // highest gpr index usable as pointer for alu pops
    localparam logic [3:0] ALU_PTR_LAST = 4'h3;
    // stack size select codes
    typedef enum logic [2:0] {
        SZ_256 = 3'b000,
        SZ_128 = 3'b001,
        SZ_64 = 3'b010,
        SZ_32 = 3'b011,
        SZ_512 = 3'b100,
        SZ_RSV5 = 3'b101,
        SZ_RSV6 = 3'b110,
        SZ_LIN = 3'b111
    } stack_size_t;
    // stack pointer operations from the core
    typedef enum logic [2:0] {
        OP_PUSH = 3'b000,
        OP_POP = 3'b001,
        OP_SUB = 3'b010,
        OP_ADD = 3'b011,
        OP_MOVE = 3'b100
    } stack_op_t;
endpackage

// ### verification/core_model.sv
// cpu core model issuing system stack operations to the mapper
module core_model
    import stack_map_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // word operation towards the mapper
    output logic o_op_valid,
    output stack_map_pkg::stack_op_t o_op_kind,
    output logic [stack_map_pkg::ADDR_W-1:0] o_op_value,
    output logic [stack_map_pkg::DATA_W-1:0] o_push_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle state at time zero
    initial begin
        o_op_valid = 1'b0;
        o_op_kind = OP_MOVE;
        o_op_value = 16'h5a5a;
        o_push_data = 16'ha5a5;
    end

    // one operation after gap + 1 idle cycles; a long gap models a slow core
    task automatic issue(input stack_op_t kind, input logic [15:0] val,
            input logic [15:0] dat, input int gap);
        repeat (gap + 1) @(posedge i_ref_clk);
        o_op_valid <= 1'b1;
        o_op_kind <= kind;
        o_op_value <= val;
        o_push_data <= dat; // whole words only
        @(posedge i_ref_clk);
        o_op_valid <= 1'b0;
        // operands go stale once taken, never left looking valid
        o_op_value <= ~val;
        o_push_data <= ~dat;
    endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the system stack address mapper
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stack_map_pkg::*;

    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic op_valid, ram_wr, ram_rd, ovt, unt, predec, is_move, mode_ok, e;
    stack_op_t op_kind;
    logic [15:0] op_value, push_data, ram_addr, ram_wdata, sp_out;
    logic [3:0] ureg;
    logic [15:0] sp, ov, un; // reference pointer state
    logic [2:0] sz;
    stack_op_t rk; // random operation kind
    int n_errors, samples_checked;

    system_stack_address_mapper dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_op_valid(op_valid),
        .i_op_kind(op_kind), .i_op_value(op_value), .i_push_data(push_data),
        .o_ram_wr(ram_wr), .o_ram_rd(ram_rd), .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata),
        .o_overflow_trap(ovt), .o_underflow_trap(unt), .i_ustk_predec(predec),
        .i_ustk_is_move(is_move), .i_ustk_reg(ureg), .o_ustk_mode_ok(mode_ok),
        .o_system_stack_pointer(sp_out));
    core_model core_u (.i_ref_clk(clk), .o_op_valid(op_valid), .o_op_kind(op_kind),
        .o_op_value(op_value), .o_push_data(push_data));

    // free-running clock
    always #5 clk = ~clk;

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // compare for word results: pointers, addresses and register data
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare for single-bit strobes and flags
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pointer as held: inside the window, even
    function automatic logic [15:0] norm(input logic [15:0] v);
        return VIRT_BASE | (v & VIRT_MOD);
    endfunction

    // physical address from the significant bits per size code
    function automatic logic [15:0] mapa(input logic [15:0] v, input logic [2:0] s);
        logic [15:0] m;
        case (s)
            3'h0: m = 16'h01ff;
            3'h1: m = 16'h00ff;
            3'h2: m = 16'h007f;
            3'h3: m = 16'h003f;
            3'h4: m = 16'h03ff;
            default: m = 16'hffff; // linear: no transformation
        endcase
        return (v & m) | (16'hfbfe & ~m);
    endfunction

    // apb transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // register write, mirrored in the reference state
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == OFS_SP) sp = norm(d[15:0]);
        if (a == OFS_OVF) ov = norm(d[15:0]);
        if (a == OFS_UNF) un = norm(d[15:0]);
        if (a == OFS_CFG) sz = d[2:0];
    endtask

    // register read with expected data and error flag
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk_bit(e, xe);
    endtask

    // one core operation, predicted then compared 1 ns after the edge that takes it
    task automatic op(input stack_op_t kind, input logic [15:0] val);
        logic [15:0] nsp, ad, dat;
        logic w, r, o, u;
        dat = 16'($urandom);
        w = (kind == OP_PUSH);
        r = (kind == OP_POP);
        ad = mapa(sp, sz);
        case (kind)
            OP_PUSH: nsp = norm(sp - 16'h2);
            OP_POP: nsp = norm(sp + 16'h2);
            OP_SUB: nsp = norm(sp - val);
            OP_ADD: nsp = norm(sp + val);
            default: nsp = norm(val);
        endcase
        if (w) ad = mapa(nsp, sz);
        o = (w || kind == OP_SUB) && nsp < ov;
        u = (r || kind == OP_ADD) && nsp > un;
        core_u.issue(kind, val, dat, int'($urandom % 3));
        #1;
        chk(sp_out, nsp);
        chk_bit(ram_wr, w);
        chk_bit(ram_rd, r);
        if (w || r) chk(ram_addr, ad);
        if (w) chk(ram_wdata, dat);
        chk_bit(ovt, o);
        chk_bit(unt, u);
        sp = nsp;
    endtask

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {predec, is_move, ureg} = '0;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(21));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        sp = RST_SP;
        ov = RST_OVF;
        un = RST_UNF;
        sz = RST_SIZE;
        rd(OFS_SP, 32'h0000fc00, 1'b0);
        rd(OFS_OVF, 32'h0000fa00, 1'b0);
        rd(OFS_UNF, 32'h0000fc00, 1'b0);
        rd(OFS_CFG, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1); // unmapped offset refused
        // wrap from the region bottom to its top, traps on the way
        op(OP_MOVE, 16'hf802);
        op(OP_PUSH, 16'h0);
        op(OP_PUSH, 16'h0);
        rd(OFS_STAT, 32'h1, 1'b0);
        wr(OFS_STAT, 32'h1);
        op(OP_POP, 16'h0);
        op(OP_MOVE, 16'hfc00);
        op(OP_POP, 16'h0);
        rd(OFS_STAT, 32'h2, 1'b0);
        op(OP_MOVE, 16'hf000);
        op(OP_PUSH, 16'h0);
        // pointer writes land even and inside the window
        wr(OFS_SP, 32'h00001235);
        rd(OFS_SP, 32'h0000f234, 1'b0);
        wr(OFS_OVF, 32'hffff3001);
        rd(OFS_OVF, 32'h0000f000, 1'b0);
        // every legal size code; reserved codes never written
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CFG, (i == 5) ? 32'h7 : 32'(i)); // 512 words assumes larger ram
            rd(OFS_CFG, 32'(sz), 1'b0);
            wr(OFS_OVF, 32'(16'hf600 + $urandom % 1024)); // limits bound the stack
            wr(OFS_UNF, 32'(16'hfa00 + $urandom % 1024));
            // start mid-ram: 25 steps of at most 16 bytes stay inside F600h..FDFEh
            op(OP_MOVE, 16'(16'hf900 + $urandom % 256)); // stays in ram
            repeat (25) begin
                rk = stack_op_t'($urandom % 5);
                op(rk, (rk == OP_MOVE) ? 16'(16'hf900 + $urandom % 256)
                    : 16'(2 * ($urandom % 8 + 1)));
            end
        end
        // user stack addressing restrictions
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            predec <= i[5];
            is_move <= i[4];
            ureg <= i[3:0];
            #1;
            chk_bit(mode_ok, i[4] || (!i[5] && i[3:0] <= 3));
        end
        complete_run();
    end
endmodule
